// ---- core/charger_ctrl_pkg.sv ----
// package: register map, field layout and timing constants of the charger control block
`default_nettype none
package charger_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_addr = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] irq_stat_addr = 8'h08;
   localparam logic [7:0] irq_mask_addr = 8'h0C;
   localparam logic [7:0] limits_addr = 8'h10;

   // control register bit positions
   localparam int ctrl_host_mode_bit = 0;
   localparam int ctrl_stat_en_bit = 1;
   localparam int ctrl_acc_en_bit = 2;
   localparam int ctrl_wdog_kick_bit = 3;
   localparam int ctrl_fault_bit = 4;

   // interrupt status bit positions
   localparam int irq_fault_bit = 0;
   localparam int irq_temp_bit = 1;
   localparam int irq_wdog_bit = 2;
   localparam int irq_cd_bit = 3;
   localparam int irq_width = 4;

   // current settings in mA; zero input limit means no limit
   localparam logic [11:0] usb_in_limit_ma = 12'h064;
   localparam logic [11:0] no_in_limit_ma = 12'h000;
   localparam logic [11:0] default_chg_ma = 12'h3E8;
   localparam logic [11:0] reduced_chg_ma = 12'h1F4;
   localparam logic [11:0] host_chg_reset_ma = 12'h1F4;
   localparam logic [11:0] host_in_reset_ma = 12'h1F4;

   // timing
   localparam int clk_mhz = 125;
   localparam int fault_pulse_us = 128;
   localparam int fault_pulse_cycles = fault_pulse_us * clk_mhz;
   localparam int wdog_s = 12;
   localparam longint wdog_cycles_l = longint'(wdog_s) * 64'd1000000 * clk_mhz;
   localparam logic [31:0] wdog_cycles = wdog_cycles_l[31:0];

   // thermistor zone encoding
   typedef enum logic [3:0] {
      zone_normal = 4'b0001,
      zone_warm = 4'b0010,
      zone_cold = 4'b0100,
      zone_hot = 4'b1000
   } temp_zone_t;

   typedef struct packed {
      logic psel;
      logic cd;
   } pins_t;

   typedef struct packed {
      logic host_mode;
      logic stat_en;
      logic acc_en;
   } ctrl_t;
endpackage : charger_ctrl_pkg
`default_nettype wire

// ---- core/pin_sync.sv ----
// module: two-flop synchroniser for the pin bundle
`default_nettype none
module pin_sync
   import charger_ctrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire pins_t pins_in,
   output pins_t pins_out
);
   typedef struct packed {
      pins_t meta;
      pins_t sync;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   always_comb begin
      next_state.meta = pins_in;
      next_state.sync = state.meta;
   end

   // cd resets low (charge on) and psel high as its pullup would
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= '{meta: '{psel: 1'b1, cd: 1'b0}, sync: '{psel: 1'b1, cd: 1'b0}};
      end else begin
         state <= next_state;
      end
   end

   assign pins_out = state.sync;
endmodule : pin_sync
`default_nettype wire

// ---- core/charger_mode_status_control.sv ----
// module: charger mode, pin status and register control logic
//
// How it works
// - disable pin high forces high impedance
// - disable toggle restarts safety timer in default only
// - source pin high: 100 mA input limit
// - source pin low: no limit, 1 A
// - status pin low while charging
// - one 128 us low pulse per fault that comes while no pulse runs
// - status pin only driven when enabled
// - accessory output follows host enable
// - default mode: cold/hot suspends, reports
// - default mode: warm zone reduces current
// - host mode: thermistor faults only reported
// - only charge and high impedance modes
// - default mode limit from source pin
// - watchdog expiry returns to default mode
`default_nettype none
module charger_mode_status_control
   import charger_ctrl_pkg::*;
#(
   parameter logic [31:0] wdog_cycles_p = wdog_cycles
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic charge_disable_pin_in,
   input wire logic source_select_pin_in,
   input wire logic [3:0] pack_thermistor_zone_in,
   input wire logic charge_done_in,
   input wire logic fault_event_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic stat_out,
   output logic stat_oe_out,
   output logic accessory_power_output_out,
   output logic charging_out,
   output logic [11:0] in_limit_ma_out,
   output logic [11:0] chg_ma_out,
   output logic safety_restart_out,
   output logic irq_out
);
   typedef enum logic [1:0] {
      mode_charge = 2'b01,
      mode_hiz = 2'b10
   } op_mode_t;

   typedef struct packed {
      ctrl_t ctrl;
      op_mode_t mode;
      logic cd_prev;
      logic [13:0] pulse_cnt;
      logic [31:0] wdog_cnt;
      logic [irq_width-1:0] irq_stat;
      logic [irq_width-1:0] irq_mask;
      logic [11:0] host_in_ma;
      logic [11:0] host_chg_ma;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic stat;
      logic stat_oe;
      logic acc;
      logic charging;
      logic [11:0] in_ma;
      logic [11:0] chg_ma;
      logic safety_restart;
      logic irq;
      logic fault_prev;
      logic temp_prev;
   } state_t;

   state_t state;
   state_t next_state;
   pins_t pins;
   temp_zone_t zone;

   localparam logic [13:0] pulse_len = 14'(fault_pulse_cycles);

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   // pins pass two flops
   pin_sync u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .pins_in('{psel: source_select_pin_in, cd: charge_disable_pin_in}),
      .pins_out(pins)
   );

   assign zone = temp_zone_t'(pack_thermistor_zone_in);

   function automatic logic is_hit(input logic [7:0] a, input logic [7:0] reg_addr);
      is_hit = (a == reg_addr);
   endfunction : is_hit

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic wr;
      logic rd;
      logic cd_edge;
      logic temp_fault;
      logic fault_rise;
      logic wdog_expire;
      logic [irq_width-1:0] events;
      wr = 1'b0;
      rd = 1'b0;
      cd_edge = 1'b0;
      temp_fault = 1'b0;
      fault_rise = 1'b0;
      wdog_expire = 1'b0;
      events = '0;
      next_state = state;

      wr = psel && penable && pwrite && !state.pready;
      rd = psel && penable && !pwrite && !state.pready;
      next_state.pready = psel && penable && !state.pready;
      next_state.pslverr = 1'b0;
      next_state.safety_restart = 1'b0;

      next_state.cd_prev = pins.cd;
      cd_edge = pins.cd ^ state.cd_prev;
      next_state.fault_prev = fault_event_in;
      temp_fault = (zone == zone_cold) || (zone == zone_hot);
      next_state.temp_prev = temp_fault;
      fault_rise = (fault_event_in && !state.fault_prev) || (temp_fault && !state.temp_prev);

      // watchdog runs in host mode, a kick or access reloads it
      wdog_expire = 1'b0;
      if (state.ctrl.host_mode) begin
         if (state.wdog_cnt == 32'h0000_0000) begin
            wdog_expire = 1'b1;
         end else begin
            next_state.wdog_cnt = state.wdog_cnt - 32'h0000_0001;
         end
      end
      if (wdog_expire) begin
         next_state.ctrl.host_mode = 1'b0;
         next_state.host_in_ma = host_in_reset_ma;
         next_state.host_chg_ma = host_chg_reset_ma;
         next_state.safety_restart = 1'b1;
      end

      // disable toggle restarts safety timer only in default mode
      if (cd_edge && !state.ctrl.host_mode) begin
         next_state.safety_restart = 1'b1;
      end

      // ---- register writes
      if (wr) begin
         next_state.wdog_cnt = wdog_cycles_p;
         if (is_hit(paddr, ctrl_addr)) begin
            next_state.ctrl.host_mode = pwdata[ctrl_host_mode_bit];
            next_state.ctrl.stat_en = pwdata[ctrl_stat_en_bit];
            next_state.ctrl.acc_en = pwdata[ctrl_acc_en_bit];
         end else if (is_hit(paddr, irq_mask_addr)) begin
            next_state.irq_mask = pwdata[irq_width-1:0];
         end else if (is_hit(paddr, limits_addr)) begin
            next_state.host_in_ma = pwdata[11:0];
            next_state.host_chg_ma = pwdata[27:16];
         end else if (!is_hit(paddr, irq_stat_addr)) begin
            next_state.pslverr = 1'b1;
         end
      end

      // ---- register reads
      if (rd) begin
         next_state.wdog_cnt = wdog_cycles_p;
         next_state.prdata = 32'h0000_0000;
         if (is_hit(paddr, ctrl_addr)) begin
            next_state.prdata[ctrl_host_mode_bit] = state.ctrl.host_mode;
            next_state.prdata[ctrl_stat_en_bit] = state.ctrl.stat_en;
            next_state.prdata[ctrl_acc_en_bit] = state.ctrl.acc_en;
         end else if (is_hit(paddr, status_addr)) begin
            next_state.prdata[3:0] = pack_thermistor_zone_in;
            next_state.prdata[4] = state.charging;
            next_state.prdata[5] = pins.cd;
            next_state.prdata[6] = pins.psel;
            next_state.prdata[7] = state.mode == mode_hiz;
         end else if (is_hit(paddr, irq_stat_addr)) begin
            next_state.prdata[irq_width-1:0] = state.irq_stat;
         end else if (is_hit(paddr, irq_mask_addr)) begin
            next_state.prdata[irq_width-1:0] = state.irq_mask;
         end else if (is_hit(paddr, limits_addr)) begin
            next_state.prdata[11:0] = state.host_in_ma;
            next_state.prdata[27:16] = state.host_chg_ma;
         end else begin
            next_state.pslverr = 1'b1;
         end
      end

      // ---- sticky interrupt status: set wins over write-one clear
      events[irq_fault_bit] = fault_rise;
      events[irq_temp_bit] = temp_fault;
      events[irq_wdog_bit] = wdog_expire;
      events[irq_cd_bit] = cd_edge;
      if (wr && is_hit(paddr, irq_stat_addr)) begin
         next_state.irq_stat = (state.irq_stat & ~pwdata[irq_width-1:0]) | events;
      end else begin
         next_state.irq_stat = state.irq_stat | events;
      end
      next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

      // disable pin picks between the two modes
      case (pins.cd)
         1'b1: next_state.mode = mode_hiz;
         default: next_state.mode = mode_charge;
      endcase

      // charging: default mode halts in cold/hot zones, host mode ignores them
      // cold or hot suspends charging in default mode
      // host mode keeps charging, faults only flagged
      next_state.charging = (next_state.mode == mode_charge) && !charge_done_in &&
         !(temp_fault && !next_state.ctrl.host_mode);

      // ---- current settings
      if (next_state.ctrl.host_mode) begin
         next_state.in_ma = next_state.host_in_ma;
         next_state.chg_ma = next_state.host_chg_ma;
      end else begin
         next_state.in_ma = pins.psel ? usb_in_limit_ma : no_in_limit_ma;
         next_state.chg_ma = default_chg_ma;
         if (zone == zone_warm) begin
            next_state.chg_ma = reduced_chg_ma;
         end
      end

      // fault pulse counter, one pulse per fault edge that comes while no pulse runs
      if (fault_rise && state.pulse_cnt == 14'h0000) begin
         next_state.pulse_cnt = pulse_len;
      end else if (state.pulse_cnt != 14'h0000) begin
         next_state.pulse_cnt = state.pulse_cnt - 14'h0001;
      end

      // open-drain status pin: enabled, then charging or pulse
      next_state.stat = 1'b0;
      next_state.stat_oe = next_state.ctrl.stat_en &&
         (next_state.charging || next_state.pulse_cnt != 14'h0000);

      // accessory output follows host enable bit
      next_state.acc = next_state.ctrl.acc_en;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state <= '0;
         state.mode <= mode_charge;
         state.wdog_cnt <= wdog_cycles_p;
         state.host_in_ma <= host_in_reset_ma;
         state.host_chg_ma <= host_chg_reset_ma;
         state.in_ma <= usb_in_limit_ma;
         state.chg_ma <= default_chg_ma;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign stat_out = state.stat;
   assign stat_oe_out = state.stat_oe;
   assign accessory_power_output_out = state.acc;
   assign charging_out = state.charging;
   assign in_limit_ma_out = state.in_ma;
   assign chg_ma_out = state.chg_ma;
   assign safety_restart_out = state.safety_restart;
   assign irq_out = state.irq;
endmodule : charger_mode_status_control
`default_nettype wire

// ---- testbench/charger_ctrl_asserts.sv ----
// checker: port-level timing rules of the charger control block
`default_nettype none
module charger_ctrl_asserts
   import charger_ctrl_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic charge_disable_pin_in,
   input wire logic charge_done_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stat_out,
   input wire logic stat_oe_out,
   input wire logic charging_out,
   input wire logic safety_restart_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // ----
   // pulse length counter
   // ----
   // counts only while not charging, so a charging period never looks like a long pulse
   int unsigned oe_len;
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         oe_len <= 0;
      end else if (stat_oe_out && !charging_out) begin
         oe_len <= oe_len + 1;
      end else begin
         oe_len <= 0;
      end
   end
   sequence s_taken;
      psel && penable && !pready;
   endsequence
   sequence s_cd_held;
      charge_disable_pin_in [*5];
   endsequence
   AST_APB_ANSWER: assert property (s_taken |=> pready) else $error("no answer after one wait");
   AST_APB_ONE: assert property (pready |=> !pready) else $error("pready held too long");
   AST_APB_ERR: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_CD_HIZ: assert property (s_cd_held |-> !charging_out)
      else $error("charging while disabled");
   AST_DONE: assert property (charge_done_in [*2] |-> !charging_out)
      else $error("charging after done");
   AST_STAT_LOW: assert property (!stat_out)
      else $error("status pin driven high");
   AST_PULSE: assert property (oe_len <= fault_pulse_cycles)
      else $error("fault pulse too long");
   AST_RESTART: assert property (safety_restart_out |=> !safety_restart_out)
      else $error("restart pulse too long");
endmodule : charger_ctrl_asserts
bind charger_mode_status_control charger_ctrl_asserts u_chk (.clk_sys_in, .rst_in,
   .charge_disable_pin_in, .charge_done_in, .psel, .penable, .pready, .pslverr,
   .stat_out, .stat_oe_out, .charging_out, .safety_restart_out);
`default_nettype wire

// ---- testbench/host_stat_model.sv ----
// partner: host side of the status pin with pull-up and low-period timer
`default_nettype none
module host_stat_model (
   input wire logic clk_in,
   input wire logic stat_in,
   input wire logic stat_oe_in,
   output logic level_out,
   output int unsigned low_len_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned run = 0;
   initial low_len_out = 0;
   assign level_out = stat_oe_in ? stat_in : 1'b1;
   always @(posedge clk_in) begin
      if (!level_out) begin
         run <= run + 1;
      end else begin
         if (run != 0) low_len_out <= run;
         run <= 0;
      end
   end
endmodule : host_stat_model
`default_nettype wire

// ---- testbench/charger_mode_status_control_tb_top.sv ----
// testbench: register, pin and status scenarios of the charger control block
`default_nettype none
module charger_mode_status_control_tb_top;
   import charger_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 0, rst_in = 1, cd = 0, src = 1, done = 0, fault = 0;
   logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, stat, oe, acc, chg, sr, irq, lvl;
   logic [3:0] zone = 4'b0001;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic [11:0] in_lim, chg_ma;
   logic e;
   int unsigned low_len, sr_cnt = 0, sr0;
   int num_errors = 0, checked = 0;
   charger_mode_status_control #(.wdog_cycles_p(32'h0000_00C8)) u_dut (.clk_sys_in,
      .rst_in, .charge_disable_pin_in(cd), .source_select_pin_in(src),
      .pack_thermistor_zone_in(zone), .charge_done_in(done), .fault_event_in(fault), .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stat_out(stat),
      .stat_oe_out(oe), .accessory_power_output_out(acc), .charging_out(chg),
      .in_limit_ma_out(in_lim), .chg_ma_out(chg_ma), .safety_restart_out(sr), .irq_out(irq));
   host_stat_model u_host (.clk_in(clk_sys_in), .stat_in(stat), .stat_oe_in(oe),
      .level_out(lvl), .low_len_out(low_len));
   initial forever #4 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) if (sr === 1'b1) sr_cnt++;
   // ----
   // tasks
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : wt
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      if (n >= 20) chk(0, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(q & m, x);
   endtask : rdm
   // ----
   // tests
   // ----
   initial begin
      #400000;
      num_errors++;
      close_out();
   end
   initial begin
      wt(2);
      rst_in <= 1'b0;
      chk(32'(in_lim), 32'h0000_0064);
      chk(32'(chg_ma), 32'h0000_03E8);
      rdm(ctrl_addr, 32'hFFFF_FFFF, 32'h0000_0000);
      rdm(limits_addr, 32'hFFFF_FFFF, 32'h01F4_01F4);
      rdm(irq_mask_addr, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk(32'(e), 1);
      chk(q, 0);
      src <= 1'b0;
      wt(6);
      chk(32'(in_lim), 32'h0000_0000);
      src <= 1'b1;
      wt(6);
      chk(32'(in_lim), 32'h0000_0064);
      $display("test start-up limits done");
      apb(1'b1, ctrl_addr, 32'h0000_0002);
      wt(2);
      chk(32'(chg), 1);
      chk(32'(lvl), 0);
      sr0 = sr_cnt;
      cd <= 1'b1;
      wt(6);
      chk(32'(chg), 0);
      chk(32'(lvl), 1);
      rdm(status_addr, 32'h0000_0080, 32'h0000_0080);
      cd <= 1'b0;
      wt(6);
      chk(32'(chg), 1);
      chk(32'(sr_cnt > sr0), 1);
      $display("test disable pin done");
      cd <= 1'b1;
      wt(6);
      fault <= 1'b1;
      wt(2);
      fault <= 1'b0;
      wt(16010);
      chk(low_len, 32'd16000);
      rdm(irq_stat_addr, 32'h0000_0001, 32'h0000_0001);
      chk(32'(irq), 0);
      apb(1'b1, irq_mask_addr, 32'h0000_0001);
      wt(2);
      chk(32'(irq), 1);
      apb(1'b1, irq_stat_addr, 32'h0000_000F);
      wt(2);
      chk(32'(irq), 0);
      apb(1'b1, ctrl_addr, 32'h0000_0000);
      fault <= 1'b1;
      wt(2);
      fault <= 1'b0;
      wt(20);
      chk(32'(lvl), 1);
      chk(32'(irq), 1);
      apb(1'b1, irq_stat_addr, 32'h0000_000F);
      cd <= 1'b0;
      $display("test fault pulse done");
      apb(1'b1, ctrl_addr, 32'h0000_0004);
      wt(2);
      chk(32'(acc), 1);
      apb(1'b1, ctrl_addr, 32'h0000_0000);
      wt(2);
      chk(32'(acc), 0);
      zone <= zone_warm;
      wt(3);
      chk(32'(chg_ma), 32'h0000_01F4);
      chk(32'(chg), 1);
      zone <= zone_cold;
      wt(3);
      chk(32'(chg), 0);
      rdm(irq_stat_addr, 32'h0000_0002, 32'h0000_0002);
      zone <= zone_normal;
      $display("test default thermistor done");
      apb(1'b1, limits_addr, 32'h0300_0200);
      apb(1'b1, ctrl_addr, 32'h0000_0001);
      wt(3);
      chk(32'(in_lim), 32'h0000_0200);
      chk(32'(chg_ma), 32'h0000_0300);
      zone <= zone_hot;
      wt(3);
      chk(32'(chg), 1);
      rdm(irq_stat_addr, 32'h0000_0002, 32'h0000_0002);
      zone <= zone_normal;
      sr0 = sr_cnt;
      cd <= 1'b1;
      wt(6);
      cd <= 1'b0;
      wt(6);
      chk(32'(sr_cnt == sr0), 1);
      wt(260);
      rdm(ctrl_addr, 32'h0000_0001, 32'h0000_0000);
      chk(32'(in_lim), 32'h0000_0064);
      chk(32'(chg), 1);
      rdm(irq_stat_addr, 32'h0000_0004, 32'h0000_0004);
      done <= 1'b1;
      wt(3);
      chk(32'(chg), 0);
      $display("test host mode and watchdog done");
      close_out();
   end
endmodule : charger_mode_status_control_tb_top
`default_nettype wire
